//--- pkg/sas_pkg.sv
// Package of constants for the successive-approximation converter sequencer.
package sas_pkg;
    // Register byte offsets on the APB slave.
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_OPTIONS = 8'h04;
    localparam logic [7:0] OFS_RES0    = 8'h08;
    localparam logic [7:0] OFS_RES1    = 8'h0c;
    localparam logic [7:0] OFS_RES2    = 8'h10;
    localparam logic [7:0] OFS_RES3    = 8'h14;
    // Control register fields.
    localparam int CTL_DONE  = 7;
    localparam int CTL_SCAN  = 5;
    localparam int CTL_GROUP = 4;
    localparam int CTL_CH_HI = 3;
    localparam int CTL_CH_LO = 0;
    // Options register fields.
    localparam int OPT_PWR   = 7;
    localparam int OPT_CONV_CLOCK_SOURCE  = 6;
    localparam int OPT_IRQ_EDGE_ONLY  = 5;
    localparam int OPT_DLY   = 4;
    localparam int OPT_CME   = 3;
    localparam logic [7:0] OPT_ONCE_MASK = 8'hb7;
    localparam logic [7:0] OPT_WR_MASK   = 8'hfb;
    localparam logic [7:0] OPT_RESET     = 8'h10;
    localparam logic [7:0] CTL_WR_MASK   = 8'h3f;
    // Timing, sizes, codes and states.
    localparam int CLK_MHZ         = 125;
    localparam int SAMPLE_CYCLES   = 12;
    localparam int BITS            = 8;
    localparam int SEQ_LEN         = 4;
    localparam int ONCE_WINDOW     = 64;
    localparam int STOP_DELAY      = 4000;
    localparam int RESUME_DELAY    = 4;
    localparam logic [7:0] CODE_MID = 8'h80;
    typedef enum logic [2:0] {SAS_IDLE, SAS_START, SAS_SAMPLE, SAS_STEP, SAS_STORE, SAS_HOLD,
                              SAS_WAKE} sas_state_t;
endpackage

//--- rtl/sas_sequencer.sv
// Sequencer for an 8-bit successive-approximation converter with APB registers.
//
// Contract
// - Four-bit channel select routes exactly one of 16 inputs to the converter.
// - Eight comparison steps per conversion, MSB first, each fixing one bit.
// - Finished approximation is copied to the result slot of that position.
// - Sampling switch closes only during 12 cycles at each conversion start.
// - Options bit 7 powers converter and charge pump; clear disables it.
// - Four readable 8-bit results; done flag shows all are valid.
// - Results update in the store cycle whether or not a bus read is sampling them.
// - Clock-source bit selects bus clock or RC oscillator for converter.
// - Sequences are four conversions, one pass or endless by repeat bit.
// - Done flag sets when the fourth conversion of a sequence completes.
// - Sequence starts one bus cycle after a control register write.
// - Codes run 00 to ff with no overflow indication.
// - Channels: eight external, four internal references, four reserved.
// - Single channel one pass: four results in slots 1 to 4, halt.
// - Single channel continuous: fifth result overwrites slot 1, cyclically.
// - Group one pass: each of four channels once into slots 1 to 4.
// - Group continuous: cycle the group, overwriting slots in order.
// - Stop or wait suspends a conversion; resume resamples and continues.
// - Delay bit set gives about 4000 cycles stop restart, else four.
// - Any control write clears done; one while powered also restarts, abandoning the old sequence.
// - Group mode ignores two low select bits; high bits pick the group.
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module sas_sequencer #(
    parameter int STOP_DELAY_CYCLES = sas_pkg::STOP_DELAY
) (
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Mode inputs.
    input  wire logic        special_mode,
    input  wire logic        stop_mode,
    input  wire logic        wait_mode,
    // Analog block.
    input  wire logic        comparator_high,
    output logic      [3:0]  channel_select,
    output logic             sample_switch,
    output logic      [7:0]  trial_code,
    output logic             converter_power_on,
    output logic             charge_pump_on,
    output logic             conv_clock_source
);
    // ****************************************************************
    // Register access
    // ****************************************************************
    logic [7:0]  ctrl;
    logic [7:0]  options;
    logic [7:0]  result [sas_pkg::SEQ_LEN];
    logic        sequence_done_flag;
    logic        once_done;
    logic [6:0]  age;
    logic        acc;
    logic        wr_ctrl;
    logic        wr_opt;
    logic        mapped;
    logic        store_now;
    logic [1:0]  pos;

    assign acc     = psel && penable;
    assign wr_ctrl = acc && pwrite && paddr == sas_pkg::OFS_CTRL;
    assign wr_opt  = acc && pwrite && paddr == sas_pkg::OFS_OPTIONS;
    assign mapped  = paddr == sas_pkg::OFS_CTRL || paddr == sas_pkg::OFS_OPTIONS ||
                     paddr == sas_pkg::OFS_RES0 || paddr == sas_pkg::OFS_RES1 ||
                     paddr == sas_pkg::OFS_RES2 || paddr == sas_pkg::OFS_RES3;

    // Zero-wait slave: every access completes in its first access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                sas_pkg::OFS_CTRL:    prdata <= {24'h0, sequence_done_flag, 1'b0, ctrl[5:0]};
                sas_pkg::OFS_OPTIONS: prdata <= {24'h0, options};
                sas_pkg::OFS_RES0:    prdata <= {24'h0, result[0]};
                sas_pkg::OFS_RES1:    prdata <= {24'h0, result[1]};
                sas_pkg::OFS_RES2:    prdata <= {24'h0, result[2]};
                sas_pkg::OFS_RES3:    prdata <= {24'h0, result[3]};
                default:              prdata <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= 8'h0;
        end else if (wr_ctrl) begin
            ctrl <= pwdata[7:0] & sas_pkg::CTL_WR_MASK;
        end
    end

    // Protected bits take one write early in life so runaway code cannot flip them later.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            options   <= sas_pkg::OPT_RESET;
            once_done <= 1'b0;
            age       <= 7'h0;
        end else begin
            if (age != 7'(sas_pkg::ONCE_WINDOW)) begin
                age <= age + 7'h1;
            end
            if (wr_opt) begin
                if (special_mode || (!once_done && age != 7'(sas_pkg::ONCE_WINDOW))) begin
                    options   <= pwdata[7:0] & sas_pkg::OPT_WR_MASK;
                    once_done <= 1'b1;
                end else begin
                    options <= (options & sas_pkg::OPT_ONCE_MASK) |
                               (pwdata[7:0] & sas_pkg::OPT_WR_MASK &
                                ~sas_pkg::OPT_ONCE_MASK);
                end
            end
        end
    end

    // ****************************************************************
    // Conversion sequencer
    // ****************************************************************
    sas_pkg::sas_state_t state;
    sas_pkg::sas_state_t resume_to;
    logic [12:0] cnt;
    logic [2:0]  bitn;
    logic [7:0]  sar;
    logic        stopped;
    logic        halted;
    logic        powered;

    assign powered   = options[sas_pkg::OPT_PWR];
    assign halted    = stop_mode || wait_mode;
    assign store_now = state == sas_pkg::SAS_STORE;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= sas_pkg::SAS_IDLE;
            resume_to <= sas_pkg::SAS_START;
            cnt       <= 13'h0;
            bitn      <= 3'h0;
            sar       <= 8'h0;
            pos       <= 2'h0;
            stopped   <= 1'b0;
        end else if (!powered) begin
            state <= sas_pkg::SAS_IDLE;
        end else if (wr_ctrl) begin
            state <= sas_pkg::SAS_START;
            pos   <= 2'h0;
        end else if (halted && state != sas_pkg::SAS_IDLE && state != sas_pkg::SAS_HOLD) begin
            state   <= sas_pkg::SAS_HOLD;
            stopped <= stop_mode;
        end else begin
            case (state)
                sas_pkg::SAS_IDLE: begin
                end
                sas_pkg::SAS_START: begin
                    state <= sas_pkg::SAS_SAMPLE;
                    cnt   <= 13'h0;
                end
                sas_pkg::SAS_SAMPLE: begin
                    if (cnt == 13'(sas_pkg::SAMPLE_CYCLES - 1)) begin
                        state <= sas_pkg::SAS_STEP;
                        bitn  <= 3'(sas_pkg::BITS - 1);
                        sar   <= sas_pkg::CODE_MID;
                    end else begin
                        cnt <= cnt + 13'h1;
                    end
                end
                sas_pkg::SAS_STEP: begin
                    // Keep or drop the trial bit, then try the next lower bit.
                    sar[bitn] <= comparator_high;
                    if (bitn == 3'h0) begin
                        state <= sas_pkg::SAS_STORE;
                    end else begin
                        sar[bitn - 3'h1] <= 1'b1;
                        bitn <= bitn - 3'h1;
                    end
                end
                sas_pkg::SAS_STORE: begin
                    pos <= pos + 2'h1;
                    cnt <= 13'h0;
                    if (pos == 2'(sas_pkg::SEQ_LEN - 1) && !ctrl[sas_pkg::CTL_SCAN]) begin
                        state <= sas_pkg::SAS_IDLE;
                    end else begin
                        state <= sas_pkg::SAS_SAMPLE;
                    end
                end
                sas_pkg::SAS_HOLD: begin
                    if (!halted) begin
                        state <= sas_pkg::SAS_WAKE;
                        cnt   <= 13'h0;
                    end
                end
                sas_pkg::SAS_WAKE: begin
                    // A suspended conversion restarts through the start state.
                    // That path, like a store between conversions, opens a full twelve-cycle window again.
                    if ((stopped && options[sas_pkg::OPT_DLY] &&
                         cnt == 13'(STOP_DELAY_CYCLES - 1)) ||
                        (!(stopped && options[sas_pkg::OPT_DLY]) &&
                         cnt == 13'(sas_pkg::RESUME_DELAY - 1))) begin
                        state <= resume_to;
                        cnt   <= 13'h0;
                    end else begin
                        cnt <= cnt + 13'h1;
                    end
                end
                default: state <= sas_pkg::SAS_IDLE;
            endcase
        end
    end

    // Results land from the store cycle, while the bus only captures reads in setup.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < sas_pkg::SEQ_LEN; i++) begin
                result[i] <= 8'h0;
            end
        end else if (store_now && powered && !wr_ctrl) begin
            result[pos] <= sar;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sequence_done_flag <= 1'b0;
        end else if (store_now && powered && !wr_ctrl &&
                     pos == 2'(sas_pkg::SEQ_LEN - 1)) begin
            sequence_done_flag <= 1'b1;
        end else if (wr_ctrl) begin
            sequence_done_flag <= 1'b0;
        end
    end

    // ****************************************************************
    // Analog drive
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_select     <= 4'h0;
            sample_switch      <= 1'b0;
            trial_code         <= 8'h0;
            converter_power_on <= 1'b0;
            charge_pump_on     <= 1'b0;
            conv_clock_source  <= 1'b0;
        end else begin
            if (ctrl[sas_pkg::CTL_GROUP]) begin
                channel_select <= {ctrl[sas_pkg::CTL_CH_HI -: 2], pos};
            end else begin
                channel_select <= ctrl[sas_pkg::CTL_CH_HI:sas_pkg::CTL_CH_LO];
            end
            sample_switch      <= powered && !wr_ctrl && !halted &&
                                  (state == sas_pkg::SAS_START ||
                                   (state == sas_pkg::SAS_SAMPLE &&
                                    cnt != 13'(sas_pkg::SAMPLE_CYCLES - 1)) ||
                                   (state == sas_pkg::SAS_STORE &&
                                    !(pos == 2'(sas_pkg::SEQ_LEN - 1) &&
                                      !ctrl[sas_pkg::CTL_SCAN])));
            trial_code         <= sar;
            converter_power_on <= powered;
            charge_pump_on     <= powered;
            conv_clock_source  <= options[sas_pkg::OPT_CONV_CLOCK_SOURCE];
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    // Run length of the sampling switch, kept only for the checks below.
    logic [3:0]  win_len;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_len <= 4'h0;
        end else if (sample_switch) begin
            win_len <= win_len + 4'h1;
        end else begin
            win_len <= 4'h0;
        end
    end

    a_done_on_fourth: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(sequence_done_flag) |-> $past(pos) == 2'h3 && $past(store_now))
        else $error("done flag rose without fourth store");
    a_write_clears_done: assert property (@(posedge pclk) disable iff (!presetn)
        wr_ctrl && powered |=> !sequence_done_flag ##1 state == sas_pkg::SAS_SAMPLE)
        else $error("control write did not clear and restart");
    a_sample_twelve: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(sample_switch) && $past(powered && !wr_ctrl && !halted)
        |-> win_len == 4'(sas_pkg::SAMPLE_CYCLES))
        else $error("sample window not twelve cycles");
    a_sample_bound: assert property (@(posedge pclk) disable iff (!presetn)
        sample_switch |-> win_len < 4'(sas_pkg::SAMPLE_CYCLES))
        else $error("sample window longer than twelve cycles");
    a_eight_steps: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(state == sas_pkg::SAS_STEP) && !wr_ctrl && !halted && powered
        |-> (state == sas_pkg::SAS_STEP && !wr_ctrl && !halted)[*8]
            ##1 state == sas_pkg::SAS_STORE or ##[1:8] (wr_ctrl || halted || !powered))
        else $error("approximation not eight steps");
    a_store_slot: assert property (@(posedge pclk) disable iff (!presetn)
        store_now && powered && !wr_ctrl |=> result[$past(pos)] == $past(sar))
        else $error("result slot not updated");
    a_one_pass_halt: assert property (@(posedge pclk) disable iff (!presetn)
        store_now && pos == 2'h3 && !ctrl[sas_pkg::CTL_SCAN] && powered && !wr_ctrl && !halted
        |=> state == sas_pkg::SAS_IDLE)
        else $error("one pass did not halt");
    a_sample_idle: assert property (@(posedge pclk) disable iff (!presetn)
        state == sas_pkg::SAS_IDLE |=> !sample_switch)
        else $error("sampling switch closed while idle");
    a_group_channel: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl[sas_pkg::CTL_GROUP] |=> channel_select[1:0] == $past(pos))
        else $error("group channel not following slot");
    a_power_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !powered |=> state == sas_pkg::SAS_IDLE && !charge_pump_on)
        else $error("converter active while powered down");
    a_halt_holds: assert property (@(posedge pclk) disable iff (!presetn)
        halted && powered && !wr_ctrl && state != sas_pkg::SAS_IDLE
        |=> state == sas_pkg::SAS_HOLD && !sample_switch)
        else $error("stop or wait did not suspend");
    a_resume_quick: assert property (@(posedge pclk) disable iff (!presetn)
        state == sas_pkg::SAS_WAKE && !(stopped && options[sas_pkg::OPT_DLY]) && powered &&
        !wr_ctrl && !halted && cnt == 13'(sas_pkg::RESUME_DELAY - 1)
        |=> state == sas_pkg::SAS_START)
        else $error("quick resume did not restart the conversion");
    a_resume_slow: assert property (@(posedge pclk) disable iff (!presetn)
        state == sas_pkg::SAS_WAKE && stopped && options[sas_pkg::OPT_DLY] && powered &&
        !wr_ctrl && !halted && cnt == 13'(STOP_DELAY_CYCLES - 1)
        |=> state == sas_pkg::SAS_START)
        else $error("delayed resume did not restart the conversion");
    a_option_lock: assert property (@(posedge pclk) disable iff (!presetn)
        wr_opt && !special_mode && (once_done || age == 7'(sas_pkg::ONCE_WINDOW))
        |=> (options & sas_pkg::OPT_ONCE_MASK) == ($past(options) & sas_pkg::OPT_ONCE_MASK))
        else $error("protected option bits changed after the write window");
    a_restart_slot: assert property (@(posedge pclk) disable iff (!presetn)
        wr_ctrl && powered |=> pos == 2'h0)
        else $error("control write did not restart at the first slot");
    a_clock_follow: assert property (@(posedge pclk) disable iff (!presetn)
        conv_clock_source == $past(options[sas_pkg::OPT_CONV_CLOCK_SOURCE]))
        else $error("clock source output not following option bit");
    a_trial_follow: assert property (@(posedge pclk) disable iff (!presetn)
        trial_code == $past(sar))
        else $error("trial code not following approximation register");
    c_full_pass: cover property (@(posedge pclk) $rose(sequence_done_flag));
    c_continuous: cover property (@(posedge pclk) store_now && pos == 2'h0 && sequence_done_flag);
    c_resume: cover property (@(posedge pclk) state == sas_pkg::SAS_WAKE ##1
                              state == sas_pkg::SAS_START);
    c_group_pass: cover property (@(posedge pclk) $rose(sequence_done_flag) &&
                                  ctrl[sas_pkg::CTL_GROUP]);
    c_stop_delay: cover property (@(posedge pclk) state == sas_pkg::SAS_WAKE && stopped &&
                                  cnt == 13'(STOP_DELAY_CYCLES - 1));
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking testbench for the converter sequencer with APB registers.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        pclk = 1'b0, presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr;
    logic        special_mode = 1'b0, stop_mode = 1'b0, wait_mode = 1'b0;
    logic        comparator_high = 1'b0;
    logic [3:0]  channel_select;
    logic        sample_switch, converter_power_on, charge_pump_on, conv_clock_source;
    logic [7:0]  trial_code;
    logic [1:0]  cmp_mode = 2'd0;
    int          failures = 0, n_tests = 0, cyc = 0, win = 0, last_win = 0;
    logic [31:0] r;
    logic        e;
    // Bias settling time after power-up, 100 us at the 8 ns bus clock.
    localparam int SETTLE_CYCLES = 12500;

    sas_sequencer #(.STOP_DELAY_CYCLES(20)) sas_sequencer_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .special_mode(special_mode), .stop_mode(stop_mode),
        .wait_mode(wait_mode), .comparator_high(comparator_high),
        .channel_select(channel_select), .sample_switch(sample_switch),
        .trial_code(trial_code), .converter_power_on(converter_power_on),
        .charge_pump_on(charge_pump_on), .conv_clock_source(conv_clock_source));

    always #4 pclk = ~pclk;

    // ********************************************************************
    // Analog stand-in and monitors.
    // ********************************************************************
    // Mode 2 makes odd channels read full scale, so slot order shows in the results.
    always @(posedge pclk) begin
        comparator_high <= (cmp_mode == 2'd2) ? channel_select[0] : cmp_mode[0];
        if (sample_switch === 1'b1) begin
            win <= win + 1;
        end else if (win != 0) begin
            last_win <= win;
            win <= 0;
        end
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            failures++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // ********************************************************************
    // APB master.
    // ********************************************************************
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) failures++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r, exp);
    endtask

    task automatic wait_done();
        int k;
        k = 0;
        do begin
            apb(1'b0, sas_pkg::OFS_CTRL, 32'h0);
            k++;
        end while (r[7] !== 1'b1 && k < 60);
        chk(r[7], 1'b1);
    endtask

    task automatic res_all(input logic [7:0] a0, a1, a2, a3);
        rd(sas_pkg::OFS_RES0, {24'h0, a0});
        rd(sas_pkg::OFS_RES1, {24'h0, a1});
        rd(sas_pkg::OFS_RES2, {24'h0, a2});
        rd(sas_pkg::OFS_RES3, {24'h0, a3});
    endtask

    // ********************************************************************
    // Scenarios.
    // ********************************************************************
    task automatic t_regs();
        rd(sas_pkg::OFS_OPTIONS, {24'h0, sas_pkg::OPT_RESET});
        rd(8'h40, 32'h0);
        chk(e, 1'b1);
        // The bus clock is far above the leakage limit, so either source is allowed.
        apb(1'b1, sas_pkg::OFS_OPTIONS, 32'hd0);
        repeat (2) @(posedge pclk);
        chk({converter_power_on, charge_pump_on, conv_clock_source}, 3'b111);
        apb(1'b1, sas_pkg::OFS_OPTIONS, 32'h00);
        rd(sas_pkg::OFS_OPTIONS, 32'h90);
        chk({converter_power_on, conv_clock_source}, 2'b10);
        apb(1'b1, sas_pkg::OFS_OPTIONS, 32'hd0);
        // No result is trusted before the bias voltages have settled.
        repeat (SETTLE_CYCLES) @(posedge pclk);
    endtask

    task automatic t_single();
        int k;
        cmp_mode = 2'd1;
        apb(1'b1, sas_pkg::OFS_CTRL, 32'h03);
        k = 0;
        while (sample_switch !== 1'b1 && k < 10) begin
            @(posedge pclk);
            k++;
        end
        chk(k <= 2, 1'b1);
        chk(channel_select, 4'h3);
        wait_done();
        chk(last_win, 12);
        res_all(8'hff, 8'hff, 8'hff, 8'hff);
        chk(trial_code, 8'hff);
        repeat (30) @(posedge pclk);
        chk(sample_switch, 1'b0);
    endtask

    task automatic t_group();
        cmp_mode = 2'd2;
        apb(1'b1, sas_pkg::OFS_CTRL, 32'h1d);
        repeat (5) @(posedge pclk);
        chk(channel_select[3:2], 2'b11);
        wait_done();
        res_all(8'h00, 8'hff, 8'h00, 8'hff);
    endtask

    task automatic t_cont(input logic [7:0] c);
        int k;
        cmp_mode = 2'd1;
        apb(1'b1, sas_pkg::OFS_CTRL, {24'h0, c});
        wait_done();
        cmp_mode = 2'd0;
        k = 0;
        do begin
            apb(1'b0, sas_pkg::OFS_RES0, 32'h0);
            k++;
        end while (r !== 32'h0 && k < 30);
        chk(r, 32'h0);
        rd(sas_pkg::OFS_RES3, 32'hff);
        apb(1'b1, sas_pkg::OFS_CTRL, 32'h03);
        rd(sas_pkg::OFS_CTRL, 32'h03);
    endtask

    task automatic t_suspend(input logic stop, input int lo_cycles);
        int k;
        cmp_mode = 2'd1;
        apb(1'b1, sas_pkg::OFS_CTRL, 32'h05);
        repeat (16) @(posedge pclk);
        stop_mode <= stop;
        wait_mode <= ~stop;
        repeat (8) @(posedge pclk);
        chk(sample_switch, 1'b0);
        stop_mode <= 1'b0;
        wait_mode <= 1'b0;
        repeat (lo_cycles) @(posedge pclk);
        chk(sample_switch, 1'b0);
        k = 0;
        while (sample_switch !== 1'b1 && k < 40) begin
            @(posedge pclk);
            k++;
        end
        chk(k < 22, 1'b1);
        repeat (14) @(posedge pclk);
        chk(last_win, 12);
        wait_done();
        res_all(8'hff, 8'hff, 8'hff, 8'hff);
    endtask

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_single();
        t_group();
        t_cont(8'h22);
        t_cont(8'h31);
        t_suspend(1'b0, 2);
        // The stop run keeps the delay bit set, so the stop delay applies, cut to 20 cycles by the parameter.
        t_suspend(1'b1, 12);
        // Special mode lifts the once-only guard, so power can be removed again.
        special_mode <= 1'b1;
        apb(1'b1, sas_pkg::OFS_OPTIONS, 32'h00);
        repeat (2) @(posedge pclk);
        chk({converter_power_on, charge_pump_on}, 2'b00);
        close_out();
    end
endmodule
`default_nettype wire
